// file: rtl/pin_mux_pkg.sv
// Package: register map, reset values and carrier types for the pin mux / GPIO block
package pin_mux_pkg;
    // Word addresses in data space
    localparam logic [15:0] ADDR_MUX_A = 16'h7090;
    localparam logic [15:0] ADDR_MUX_B = 16'h7092;
    localparam logic [15:0] ADDR_MUX_C = 16'h7094;
    localparam logic [15:0] ADDR_PORT_E = 16'h7095;
    localparam logic [15:0] ADDR_PORT_F = 16'h7096;
    localparam logic [15:0] ADDR_PORT_A = 16'h7098;
    localparam logic [15:0] ADDR_PORT_B = 16'h709A;
    localparam logic [15:0] ADDR_PORT_C = 16'h709C;
    localparam logic [15:0] ADDR_PORT_D = 16'h709E;
    // Field layout of a port register
    localparam int DATA_LSB = 0;
    localparam int DIR_LSB = 8;
    localparam int PORT_PINS = 8;
    localparam int NUM_PORTS = 6;
    // Port indices
    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] PORT_C = 3'h2;
    localparam logic [2:0] PORT_D = 3'h3;
    localparam logic [2:0] PORT_E = 3'h4;
    localparam logic [2:0] PORT_F = 3'h5;
    // Reset values
    localparam logic [15:0] MUX_A_RST = 16'h0000;
    localparam logic [15:0] MUX_B_RST = 16'hFE03;
    localparam logic [15:0] MUX_C_RST = 16'h0001;
    localparam logic [15:0] PORT_RST = 16'h0000;

    // Processor data-space access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bus_req_t;

    // Two-signal pad group for one 8-pin port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pad_drive_t;
endpackage : pin_mux_pkg

// file: rtl/shared_pin_mux_gpio.sv
// Shared-pin multiplexer and GPIO ports A to F with data-space registers
//
// Operation
// - Mux bit 1 routes pin to peripheral function, 0 to GPIO.
// - Data and direction bits act only while pin is in GPIO mode.
// - Direction bit 0 makes pin input, 1 makes it output.
// - Output pins drive data bit; input pins read back pin level.
// - Pin n uses data bit n and direction bit n plus 8.
// - Reset: port E pin 0 is clock output, other E/F pins GPIO.
// - Reset: write/read strobe shared pin comes up in strobe function.
// - Mux control A, B, C decode at 7090h, 7092h, 7094h.
// - Ports E, F, A decode at 7095h, 7096h, 7098h.
// - Ports B, C, D decode at 709Ah, 709Ch, 709Eh.
// - All registers reachable by ordinary data-space reads and writes.
`timescale 1ns/1ps
module shared_pin_mux_gpio (
    input wire logic clk_i,                          // Processor clock, 40 MHz
    input wire logic rst_i,                          // Synchronous reset, active high
    input wire pin_mux_pkg::bus_req_t bus_i,         // Data-space read/write request
    output logic [15:0] rdata_o,                     // Read data, registered
    output logic hit_o,                              // Access decoded to this block
    input wire logic [47:0] pin_level_i,             // Pad levels, ports A..F, 8 each
    output logic [47:0] pin_out_o,                   // Pad output levels
    output logic [47:0] pin_oe_o,                    // Pad output enables, high drives
    input wire logic [47:0] periph_out_i,            // Peripheral outputs per pin
    input wire logic [47:0] periph_oe_i,             // Peripheral output enables per pin
    output logic [47:0] periph_in_o,                 // Pin levels to peripherals
    output logic [47:0] gpio_sel_o                   // High where pin is in GPIO mode
);
    // Map an address to a port index; returns 3'h7 for no port
    function automatic logic [2:0] port_of(input logic [15:0] a);
        case (a)
            pin_mux_pkg::ADDR_PORT_A: port_of = pin_mux_pkg::PORT_A;
            pin_mux_pkg::ADDR_PORT_B: port_of = pin_mux_pkg::PORT_B;
            pin_mux_pkg::ADDR_PORT_C: port_of = pin_mux_pkg::PORT_C;
            pin_mux_pkg::ADDR_PORT_D: port_of = pin_mux_pkg::PORT_D;
            pin_mux_pkg::ADDR_PORT_E: port_of = pin_mux_pkg::PORT_E;
            pin_mux_pkg::ADDR_PORT_F: port_of = pin_mux_pkg::PORT_F;
            default: port_of = 3'h7;
        endcase
    endfunction : port_of

    logic [15:0] mux_a_r;
    logic [15:0] mux_b_r;
    logic [15:0] mux_c_r;
    logic [15:0] port_r [pin_mux_pkg::NUM_PORTS];
    logic [47:0] pin_sync_r;
    logic [47:0] mux_sel;
    logic [2:0] wr_port;
    logic [2:0] rd_port;
    logic [15:0] rdata_nxt;

    assign wr_port = port_of(bus_i.addr);
    assign rd_port = wr_port;
    assign hit_o = (wr_port != 3'h7) || (bus_i.addr == pin_mux_pkg::ADDR_MUX_A)
        || (bus_i.addr == pin_mux_pkg::ADDR_MUX_B) || (bus_i.addr == pin_mux_pkg::ADDR_MUX_C);

    // Mux control registers; reset leaves strobe and clock-out pins in function mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mux_a_r <= pin_mux_pkg::MUX_A_RST;
            mux_b_r <= pin_mux_pkg::MUX_B_RST;
            mux_c_r <= pin_mux_pkg::MUX_C_RST;
        end else if (bus_i.wr) begin
            // Mux B upper bits are stored as written; software must keep them set
            if (bus_i.addr == pin_mux_pkg::ADDR_MUX_A) mux_a_r <= bus_i.wdata;
            if (bus_i.addr == pin_mux_pkg::ADDR_MUX_B) mux_b_r <= bus_i.wdata;
            if (bus_i.addr == pin_mux_pkg::ADDR_MUX_C) mux_c_r <= bus_i.wdata;
        end
    end

    // Per-pin mux select in A..F order: A=mux A low, B=mux A high, C/D=mux B, E/F=mux C
    assign mux_sel = {mux_c_r, mux_b_r, mux_a_r};

    // Pin sampling; pads are taken as synchronous, one stage keeps reads registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync_r <= 48'h0;
        end else begin
            pin_sync_r <= pin_level_i;
        end
    end

    // Port registers and pad steering, one generate instance per port
    genvar p;
    genvar n;
    generate
        for (p = 0; p < pin_mux_pkg::NUM_PORTS; p++) begin : g_port
            // Data bits always store; pad only follows them for GPIO outputs
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    port_r[p] <= pin_mux_pkg::PORT_RST;
                end else if (bus_i.wr && (wr_port == 3'(p))) begin
                    port_r[p] <= bus_i.wdata;
                end
            end
            for (n = 0; n < pin_mux_pkg::PORT_PINS; n++) begin : g_pin
                localparam int PIN = p * pin_mux_pkg::PORT_PINS + n;
                logic dir;
                logic dat;
                assign dir = port_r[p][pin_mux_pkg::DIR_LSB + n];
                assign dat = port_r[p][pin_mux_pkg::DATA_LSB + n];
                assign gpio_sel_o[PIN] = ~mux_sel[PIN];
                // Function mode hands the pad to the peripheral
                assign pin_out_o[PIN] = mux_sel[PIN] ? periph_out_i[PIN] : dat;
                assign pin_oe_o[PIN] = mux_sel[PIN] ? periph_oe_i[PIN] : dir;
                // Peripheral sees the pin only in function mode, else idle low
                assign periph_in_o[PIN] = mux_sel[PIN] & pin_level_i[PIN];
            end
        end
    endgenerate

    // Readback: output pins return latch, input pins return sampled level
    always_comb begin
        rdata_nxt = 16'h0000;
        case (bus_i.addr)
            pin_mux_pkg::ADDR_MUX_A: rdata_nxt = mux_a_r;
            pin_mux_pkg::ADDR_MUX_B: rdata_nxt = mux_b_r;
            pin_mux_pkg::ADDR_MUX_C: rdata_nxt = mux_c_r;
            default: begin
                if (rd_port != 3'h7) begin
                    for (int i = 0; i < pin_mux_pkg::PORT_PINS; i++) begin
                        rdata_nxt[pin_mux_pkg::DIR_LSB + i] =
                            port_r[rd_port][pin_mux_pkg::DIR_LSB + i];
                        rdata_nxt[pin_mux_pkg::DATA_LSB + i] =
                            port_r[rd_port][pin_mux_pkg::DIR_LSB + i]
                            ? port_r[rd_port][pin_mux_pkg::DATA_LSB + i]
                            : pin_sync_r[rd_port * pin_mux_pkg::PORT_PINS + i];
                    end
                end
            end
        endcase
    end

    // Read data held until the next read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (bus_i.rd) begin
            rdata_o <= rdata_nxt;
        end
    end
endmodule : shared_pin_mux_gpio

// file: verif/board_pads.sv
// Board model: resolves every pin from device drive and board level
`timescale 1ns/1ps
module board_pads (
    input wire logic [47:0] out_i, // Device pad value
    input wire logic [47:0] oe_i, // Device pad enable
    input wire logic [47:0] ext_i, // Board level on undriven pins
    output logic [47:0] level_o // Resolved pin level
);
    // Device wins where it drives, so a stale value never looks like a read
    assign level_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule : board_pads

// file: verif/shared_pin_mux_gpio_chk.sv
// Concurrent checks on the pin mux and GPIO ports
`timescale 1ns/1ps
module shared_pin_mux_gpio_chk (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Sync reset
    input wire pin_mux_pkg::bus_req_t bus_i, // Request
    input wire logic [15:0] rdata_o, // Read data
    input wire logic hit_o, // Decode hit
    input wire logic [47:0] pin_level_i, // Pad level
    input wire logic [47:0] pin_out_o, // Pad value
    input wire logic [47:0] pin_oe_o, // Pad enable
    input wire logic [47:0] periph_out_i, // Function value
    input wire logic [47:0] periph_oe_i, // Function enable
    input wire logic [47:0] periph_in_o, // Function input
    input wire logic [47:0] gpio_sel_o // GPIO mode
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Function-mode mask
    wire [47:0] f = ~gpio_sel_o;
    // Writes to mux A and to port A
    sequence mux_a_wr;
        bus_i.wr && bus_i.addr == 16'h7090;
    endsequence
    sequence port_a_wr;
        bus_i.wr && bus_i.addr == 16'h7098;
    endsequence
    mux_out_a: assert property ((pin_out_o & f) == (periph_out_i & f))
        else $error("function pin value not routed");
    mux_oe_a: assert property ((pin_oe_o & f) == (periph_oe_i & f))
        else $error("function pin enable not routed");
    fn_in_a: assert property (periph_in_o == (pin_level_i & f))
        else $error("function input wrong");
    reset_mux_a: assert property ($past(rst_i) |-> (gpio_sel_o ==
        ~{16'h0001, 16'hFE03, 16'h0000}) && (pin_oe_o & gpio_sel_o) == 48'h0)
        else $error("mux reset state wrong");
    mux_wr_a: assert property (mux_a_wr |=> gpio_sel_o[15:0] == ~$past(bus_i.wdata))
        else $error("mux A write not applied");
    port_dir_a: assert property (port_a_wr |=> (pin_oe_o[7:0] & gpio_sel_o[7:0]) ==
        ($past(bus_i.wdata[15:8]) & gpio_sel_o[7:0])) else $error("direction bits wrong");
    port_data_a: assert property (port_a_wr |=> ((pin_out_o[7:0] ^
        $past(bus_i.wdata[7:0])) & pin_oe_o[7:0] & gpio_sel_o[7:0]) == 8'h00)
        else $error("data bits not driven");
    decode_a: assert property (hit_o == (bus_i.addr inside {16'h7090, 16'h7092,
        [16'h7094:16'h7096], 16'h7098, 16'h709A, 16'h709C, 16'h709E})) else $error("bad decode");
endmodule : shared_pin_mux_gpio_chk
bind shared_pin_mux_gpio shared_pin_mux_gpio_chk watch (.*);

// file: verif/shared_pin_mux_gpio_tb.sv
// Self-checking testbench for the pin mux and GPIO block
`timescale 1ns/1ps
module shared_pin_mux_gpio_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    pin_mux_pkg::bus_req_t bus_i = '0;
    logic [15:0] rdata_o, got;
    logic hit_o;
    logic [47:0] lvl, pout, poe, pin, sel;
    logic [47:0] ext = 48'h3C5A96F0A55A;
    logic [47:0] p_out = 48'hF0F00F0FCC33;
    logic [47:0] p_oe = 48'h000000000000;
    logic [15:0] addrs [9] = '{16'h7090, 16'h7092, 16'h7094, 16'h7095, 16'h7096,
        16'h7098, 16'h709A, 16'h709C, 16'h709E};
    int errors = 0;
    int n_compared = 0;
    shared_pin_mux_gpio dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .hit_o(hit_o), .pin_level_i(lvl), .pin_out_o(pout), .pin_oe_o(poe),
        .periph_out_i(p_out), .periph_oe_i(p_oe), .periph_in_o(pin), .gpio_sel_o(sel));
    board_pads pads (.out_i(pout), .oe_i(poe), .ext_i(ext), .level_o(lvl));
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] act);
        n_compared++;
        if (act !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", what, exp, act);
        end
    endtask : chk
    // Bus cycles: one request per cycle, inputs moved at the falling edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_i);
        bus_i = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clk_i);
        bus_i.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(negedge clk_i);
        bus_i = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(negedge clk_i);
        bus_i.rd = 1'b0;
        got = rdata_o;
    endtask : rd
    task automatic do_reset;
        rst_i = 1'b1;
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
    endtask : do_reset
    task automatic wrap_up;
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        do_reset();
        chk("reset sel", ~{16'h0001, 16'hFE03, 16'h0000}, sel);
        chk("reset oe", 48'h0, poe);
        chk("fn drive", p_out & ~sel, pout & ~sel);
        chk("fn input", ext & {16'h0001, 16'hFE03, 16'h0000}, pin);
        wr(16'h7098, 16'h0F5A);
        chk("port a oe", 48'h0F, poe);
        chk("port a out", 48'h0A, pout & 48'h0F);
        rd(16'h7098);
        chk("port a read", {32'h0, 8'h0F, ext[7:4], 4'hA}, {32'h0, got});
        wr(16'h7090, 16'h0001);
        chk("a0 function", 48'h0E, poe);
        chk("a0 drive", {47'h0, p_out[0]}, pout & 48'h1);
        // Every register; mux B writes keep bits 15..9 set
        // No system control register here, so its reserved bit is never touched
        for (int i = 0; i < 9; i++) begin
            wr(addrs[i], {8'hFF, 8'(i * 17)});
            rd(addrs[i]);
            chk("readback", {32'h0, 8'hFF, 8'(i * 17)}, {32'h0, got});
            chk("hit", 48'h1, {47'h0, hit_o});
        end
        // Strobe pin handed to GPIO by clearing mux B bit 0 first
        wr(16'h7092, 16'hFE02);
        chk("c0 gpio oe", 48'h1, {47'h0, poe[16]});
        chk("c0 gpio out", 48'h1, {47'h0, pout[16]});
        wr(16'h7097, 16'hFFFF);
        rd(16'h7097);
        chk("unmapped", 48'h0, {32'h0, got});
        chk("unmapped hit", 48'h0, {47'h0, hit_o});
        do_reset();
        chk("re-reset sel", ~{16'h0001, 16'hFE03, 16'h0000}, sel);
        chk("re-reset oe", 48'h0, poe);
        wrap_up();
    end
    // Watchdog well beyond the run length
    initial begin
        #(25 * 500);
        errors++;
        wrap_up();
    end
endmodule : shared_pin_mux_gpio_tb
